// >>> sas_front_model.sv
// Purpose: input mux, sample-and-hold and comparator as codes
// Assumes: input voltages given as ideal 8-bit codes
// Notes:   invalid pins and a dark comparator give changing junk
`timescale 1ns/1ps
module sas_front_model (
  input  wire        pclk,           // clock
  input  wire [63:0] vin_bus,        // input codes, channel 0 low
  input  wire        sample_on,      // sample switch
  input  wire        comparator_on,  // comparator power
  input  wire [7:0]  tap_code,       // tap select
  input  wire [2:0]  analog_channel, // mux select
  input  wire [7:0]  analog_pin_cfg, // 0 = analog
  input  wire [7:0]  port_dir,       // 1 = input
  output reg         comp_out        // held >= tap
);
  // ----------------------------------------------------------------
  // analog path
  // ----------------------------------------------------------------
  reg  [7:0] held_q = 8'h00;
  reg        junk_q = 1'h0;
  wire       pin_ok = !analog_pin_cfg[analog_channel] && port_dir[analog_channel];
  // track while sampling, keep the value in hold; bad pins give junk
  always @(posedge pclk) begin
    junk_q <= ~junk_q;
    if (sample_on)
      held_q <= pin_ok ? vin_bus[{analog_channel, 3'h0} +: 8] : ~held_q;
  end
  // a powered-down comparator toggles so no stale answer passes
  always @* comp_out = comparator_on ? (held_q >= tap_code) : junk_q;
endmodule

// >>> sas_regs.vh
// Purpose: register map, field positions, reset values and timing counts
//          for the successive-approximation converter sequencer
// Assumes: 32-bit APB, one register per aligned word
// Notes:   definitions only
`ifndef SAS_REGS_VH
`define SAS_REGS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define SAS_MODE_OFS      12'h000
`define SAS_CHAN_OFS      12'h004
`define SAS_PINCFG_OFS    12'h008
`define SAS_PORTDIR_OFS   12'h00C
`define SAS_RESULT_OFS    12'h010
`define SAS_FLAG_OFS      12'h014
`define SAS_MASK_OFS      12'h018
`define SAS_STATUS_OFS    12'h01C

// ----------------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------------
`define SAS_MODE_ENABLE   0
`define SAS_MODE_TIME_LO  1
`define SAS_MODE_TIME_HI  5
`define SAS_MODE_START    7
`define SAS_MODE_WMASK    8'hBF

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SAS_MODE_RST      8'h00
`define SAS_CHAN_RST      3'h0
`define SAS_PINCFG_RST    8'h00
`define SAS_PORTDIR_RST   8'hFF
`define SAS_RESULT_RST    8'h00
`define SAS_MASK_RST      1'b1

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SAS_CLK_NS        100
`define SAS_SAMPLE_STEPS  4
`define SAS_BITS          8

`endif

// >>> sas_sequencer.v
// Purpose: control logic of an 8-bit successive-approximation converter
// Assumes: APB slave, comparator and sample switch are analog macros outside
// Notes:   all outputs registered; one comparator decision per step tick
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "sas_regs.vh"

module sas_sequencer (
  input  wire        pclk,             // peripheral clock, 10 MHz
  input  wire        presetn,          // async reset, active low
  input  wire        psel,             // apb select
  input  wire        penable,          // apb access phase
  input  wire        pwrite,           // apb direction
  input  wire [11:0] paddr,            // apb byte address
  input  wire [31:0] pwdata,           // apb write data
  output reg  [31:0] prdata,           // apb read data
  output reg         pready,           // apb ready
  output reg         pslverr,          // apb error, unmapped address
  input  wire        comp_out,         // comparator: held input >= tap
  output reg         comparator_on,    // comparator power
  output reg         sample_on,        // sample switch closed
  output reg  [7:0]  tap_code,         // resistor-string tap select
  output reg  [2:0]  analog_channel,   // input multiplexer select
  output reg  [7:0]  analog_pin_cfg,   // pin analog/digital select
  output reg  [7:0]  port_dir,         // pin direction, 1 = input
  output reg         conversion_end_irq // request flag, gated off while mask is set
);

  // ----------------------------------------------------------------------
  // states
  // ----------------------------------------------------------------------
  localparam ST_IDLE   = 2'h0;
  localparam ST_SAMPLE = 2'h1;
  localparam ST_TRIAL  = 2'h2;
  localparam ST_STORE  = 2'h3;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  reg  [7:0] converter_mode_reg;
  reg  [2:0] channel_select_reg;
  reg  [7:0] approximation_reg;
  reg  [7:0] conversion_result_reg;
  reg        conversion_irq_flag;
  reg        conversion_irq_mask;
  reg  [1:0] state_q;
  reg  [2:0] bit_q;
  reg  [2:0] samp_q;
  reg        pend_q;
  reg  [7:0] pend_val_q;
  reg        clr_q;

  wire       wr_en;
  wire       rd_en;
  wire       wr_mode;
  wire       wr_chan;
  wire       wr_pin;
  wire       wr_ctrl;
  wire       rd_result;
  wire       tick;
  wire       start;
  wire       done;
  wire [7:0] trial;

  // one-hot mask for the current trial bit
  function [7:0] bit_mask;
    input [2:0] idx;
    begin
      bit_mask = 8'h01 << idx;
    end
  endfunction

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  assign wr_en     = psel & penable & pwrite;
  assign rd_en     = psel & penable & ~pwrite;
  assign wr_mode   = wr_en & (paddr == `SAS_MODE_OFS);
  assign wr_chan   = wr_en & (paddr == `SAS_CHAN_OFS);
  assign wr_pin    = wr_en & (paddr == `SAS_PINCFG_OFS);
  assign wr_ctrl   = wr_mode | wr_chan | wr_pin;
  assign rd_result = rd_en & (paddr == `SAS_RESULT_OFS);
  assign start     = converter_mode_reg[`SAS_MODE_START];
  assign done      = (state_q == ST_TRIAL) & tick & (bit_q == 3'h0);
  assign trial     = approximation_reg & ~bit_mask(bit_q) | (comp_out ? bit_mask(bit_q) : 8'h00);

  // step pacing from the time-select field
  sas_step_timer #(
    .SEL_W (5)
  ) u_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    .clr      (clr_q),
    .time_sel (converter_mode_reg[`SAS_MODE_TIME_HI:`SAS_MODE_TIME_LO]),
    .tick     (tick)
  );

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_mode_reg  <= `SAS_MODE_RST;
      channel_select_reg  <= `SAS_CHAN_RST;
      analog_pin_cfg      <= `SAS_PINCFG_RST;
      port_dir            <= `SAS_PORTDIR_RST;
      conversion_irq_mask <= `SAS_MASK_RST;
    end else if (wr_en) begin
      if (paddr == `SAS_MODE_OFS) begin
        converter_mode_reg <= pwdata[7:0] & `SAS_MODE_WMASK;
      end else if (paddr == `SAS_CHAN_OFS) begin
        channel_select_reg <= pwdata[2:0];
      end else if (paddr == `SAS_PINCFG_OFS) begin
        analog_pin_cfg <= pwdata[7:0];
      end else if (paddr == `SAS_PORTDIR_OFS) begin
        port_dir <= pwdata[7:0];
      end else if (paddr == `SAS_MASK_OFS) begin
        conversion_irq_mask <= pwdata[0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  // a control write restarts the pacing timer a cycle later; a tick due in the write cycle still ends the first step
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q           <= ST_IDLE;
      approximation_reg <= 8'h00;
      bit_q             <= 3'h7;
      samp_q            <= 3'h0;
      clr_q             <= 1'b1;
    end else begin
      clr_q <= 1'b0;
      if (wr_mode & ~pwdata[`SAS_MODE_START]) begin
        state_q <= ST_IDLE;
        clr_q   <= 1'b1;
      end else if (wr_ctrl) begin
        // abandoned; restart from sampling if start will be set
        state_q <= (wr_mode ? pwdata[`SAS_MODE_START] : start) ? ST_SAMPLE : ST_IDLE;
        samp_q  <= 3'h0;
        clr_q   <= 1'b1;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (start) begin
              state_q <= ST_SAMPLE;
              samp_q  <= 3'h0;
              clr_q   <= 1'b1;
            end
          end
          ST_SAMPLE: begin
            if (tick) begin
              if (samp_q == (`SAS_SAMPLE_STEPS - 1)) begin
                state_q           <= ST_TRIAL;
                approximation_reg <= 8'h80;
                bit_q             <= 3'h7;
              end else begin
                samp_q <= samp_q + 3'h1;
              end
            end
          end
          ST_TRIAL: begin
            if (tick) begin
              if (bit_q == 3'h0) begin
                approximation_reg <= trial;
                state_q           <= ST_STORE;
              end else begin
                // keep or drop this bit, then try the next one
                approximation_reg <= trial | bit_mask(bit_q - 3'h1);
                bit_q             <= bit_q - 3'h1;
              end
            end
          end
          default: begin
            state_q <= start ? ST_SAMPLE : ST_IDLE;
            samp_q  <= 3'h0;
            clr_q   <= 1'b1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // result store and request flag
  // ----------------------------------------------------------------------
  // the store is the cycle after the last trial; a clash with a result
  // read defers it one cycle, a clash with a control write cancels it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_result_reg <= `SAS_RESULT_RST;
      conversion_irq_flag   <= 1'b0;
      pend_q                <= 1'b0;
      pend_val_q            <= 8'h00;
    end else begin
      if (pend_q) begin
        conversion_result_reg <= pend_val_q;
        pend_q                <= 1'b0;
      end else if ((state_q == ST_STORE) & ~wr_ctrl) begin
        if (rd_result) begin
          pend_q     <= 1'b1;
          pend_val_q <= approximation_reg;
        end else begin
          conversion_result_reg <= approximation_reg;
        end
      end
      // hardware set wins over software clear; channel writes leave it
      if ((state_q == ST_STORE) & ~wr_ctrl) begin
        conversion_irq_flag <= 1'b1;
      end else if (wr_en & (paddr == `SAS_FLAG_OFS) & ~pwdata[0]) begin
        conversion_irq_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // analog side outputs
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comparator_on      <= 1'b0;
      sample_on          <= 1'b0;
      tap_code           <= 8'h00;
      analog_channel     <= 3'h0;
      conversion_end_irq <= 1'b0;
    end else begin
      comparator_on      <= converter_mode_reg[`SAS_MODE_ENABLE];
      sample_on          <= (state_q == ST_SAMPLE);
      tap_code           <= approximation_reg;
      analog_channel     <= channel_select_reg;
      conversion_end_irq <= conversion_irq_flag & ~conversion_irq_mask;
    end
  end

  // ----------------------------------------------------------------------
  // apb answer, zero wait states
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel & ~penable) begin
        if (paddr == `SAS_MODE_OFS) begin
          prdata <= {24'h000000, converter_mode_reg};
        end else if (paddr == `SAS_CHAN_OFS) begin
          prdata <= {29'h00000000, channel_select_reg};
        end else if (paddr == `SAS_PINCFG_OFS) begin
          prdata <= {24'h000000, analog_pin_cfg};
        end else if (paddr == `SAS_PORTDIR_OFS) begin
          prdata <= {24'h000000, port_dir};
        end else if (paddr == `SAS_RESULT_OFS) begin
          prdata <= {24'h000000, conversion_result_reg};
        end else if (paddr == `SAS_FLAG_OFS) begin
          prdata <= {31'h00000000, conversion_irq_flag};
        end else if (paddr == `SAS_MASK_OFS) begin
          prdata <= {31'h00000000, conversion_irq_mask};
        end else if (paddr == `SAS_STATUS_OFS) begin
          prdata <= {27'h0000000, bit_q, state_q};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

endmodule

// >>> sas_sequencer_chk.sv
// Purpose: port-level checks of the converter sequencer
// Assumes: zero-wait apb slave, step of two cycles or more
// Notes:   bound into sas_sequencer below
`timescale 1ns/1ps
`include "sas_regs.vh"
module sas_chk (
  input wire        pclk,               // clock
  input wire        presetn,            // reset, active low
  input wire        psel,               // apb select
  input wire        penable,            // apb access
  input wire        pwrite,             // apb direction
  input wire [11:0] paddr,              // apb address
  input wire [31:0] pwdata,             // apb write data
  input wire [31:0] prdata,             // apb read data
  input wire        pready,             // apb ready
  input wire        pslverr,            // apb error
  input wire        comp_out,           // comparator answer
  input wire        comparator_on,      // comparator power
  input wire        sample_on,          // sample switch
  input wire [7:0]  tap_code,           // tap select
  input wire [2:0]  analog_channel,     // mux select
  input wire [7:0]  analog_pin_cfg,     // pin mode
  input wire [7:0]  port_dir,           // pin direction
  input wire        conversion_end_irq  // request
);
  // ----------------------------------------------------------------
  // helpers and assertions
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire       wr = psel && penable && pready && pwrite;
  reg  [7:0] samp_q;
  reg  [2:0] bus_q;
  // sample length; saturates so a long-held switch cannot wrap to a short count and fail
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_q <= 8'h00;
      bus_q  <= 3'h0;
    end else begin
      samp_q <= !sample_on ? 8'h00 : (samp_q == 8'hFF) ? samp_q : samp_q + 8'h01;
      bus_q  <= {bus_q[1:0], psel};
    end
  end
  a_zero_wait: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_unmapped_err: assert property (psel && !penable && paddr > 12'h01C |=> pslverr)
    else $error("no error on unmapped address");
  a_enable_comp: assert property (wr && paddr == `SAS_MODE_OFS
    |=> ##1 comparator_on == $past(pwdata[0], 2)) else $error("comparator power wrong");
  a_chan_output: assert property (wr && paddr == `SAS_CHAN_OFS
    |=> ##1 analog_channel == $past(pwdata[2:0], 2)) else $error("channel not applied");
  a_pin_cfg: assert property (wr && paddr == `SAS_PINCFG_OFS
    |=> analog_pin_cfg == $past(pwdata[7:0])) else $error("pin mode not applied");
  a_sample_len: assert property ($fell(sample_on) && bus_q == 3'h0
    |-> samp_q >= 8'h08) else $error("sampling too short");
  a_first_tap: assert property ($fell(sample_on) && bus_q == 3'h0
    |-> ##[0:2] tap_code == 8'h80) else $error("first tap not half");
  a_second_tap: assert property ($past(tap_code) == 8'h80 && tap_code != 8'h80
    |-> tap_code[5:0] == 6'h00 && (tap_code[6] || tap_code == 8'h00))
    else $error("second tap not a quarter step");
  a_msb_held: assert property ($changed(tap_code) && tap_code == 8'h80 && !psel
    |=> $stable(tap_code)) else $error("trial step too short");
  a_stop_quiet: assert property (wr && paddr == `SAS_MODE_OFS && !pwdata[7]
    |=> ##2 (!sample_on && !$rose(conversion_end_irq))[*8]) else $error("runs after stop");
endmodule
bind sas_sequencer sas_chk u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .comp_out, .comparator_on, .sample_on, .tap_code,
  .analog_channel, .analog_pin_cfg, .port_dir, .conversion_end_irq
);

// >>> sas_sequencer_tb.sv
// Purpose: self-checking bench for the converter sequencer
// Assumes: zero-wait apb, step = (time field + 1) * 2 cycles
// Notes:   analog side is a code-level model
`timescale 1ns/1ps
`include "sas_regs.vh"
module sas_sequencer_tb;
  // ----------------------------------------------------------------
  // bench
  // ----------------------------------------------------------------
  reg         pclk, presetn, psel, penable, pwrite, rerr;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rdata;
  reg  [63:0] vin_bus;
  reg  [7:0]  vtab [0:3];
  reg  [4:0]  ttab [0:3];
  wire [31:0] prdata;
  wire [7:0]  tap_code, analog_pin_cfg, port_dir;
  wire [2:0]  analog_channel;
  wire        pready, pslverr, comp_out, comparator_on, sample_on, conversion_end_irq;
  integer     err_total, tests_run, n, i;
  sas_sequencer dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .comp_out, .comparator_on, .sample_on, .tap_code,
    .analog_channel, .analog_pin_cfg, .port_dir, .conversion_end_irq
  );
  sas_front_model u_front (
    .pclk, .vin_bus, .sample_on, .comparator_on, .tap_code,
    .analog_channel, .analog_pin_cfg, .port_dir, .comp_out
  );
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        err_total = err_total + 1;
      end
    end
  endtask
  // one apb transfer; request held until ready is sampled
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel    <= 1'h1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'h1 && n < 20) begin
        @(posedge pclk);
        n = n + 1;
      end
      if (n >= 20) err_total = err_total + 1;
      rdata = prdata;
      rerr  = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
    end
  endtask
  // bounded wait; n ends as the cycle count
  task wait_irq;
    begin
      n = 0;
      while (conversion_end_irq !== 1'h1 && n < 4000) begin
        @(posedge pclk);
        n = n + 1;
      end
      if (n >= 4000) err_total = err_total + 1;
    end
  endtask
  task results;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end
  // watchdog, well past the longest sequence
  initial begin
    repeat (60000) @(posedge pclk);
    err_total = err_total + 1;
    results;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, vin_bus} = 0;
    {err_total, tests_run} = 0;
    {vtab[0], vtab[1], vtab[2], vtab[3]} = 32'h00FF6B81;
    {ttab[0], ttab[1], ttab[2], ttab[3]} = 20'h0_8_A_F;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    apb(0, `SAS_RESULT_OFS, 0); chk(rdata, 32'h00);
    apb(0, `SAS_PORTDIR_OFS, 0); chk(rdata, {24'h0, `SAS_PORTDIR_RST});
    apb(0, `SAS_MASK_OFS, 0); chk(rdata, 32'h1);
    apb(1, `SAS_RESULT_OFS, 32'h5A); apb(0, `SAS_RESULT_OFS, 0); chk(rdata, 32'h0);
    apb(0, 12'h020, 0); chk(rerr, 1);
    chk(rdata, 0);
    apb(1, `SAS_PINCFG_OFS, 32'hA5); apb(0, `SAS_PINCFG_OFS, 0); chk(rdata, 32'hA5);
    apb(1, `SAS_PINCFG_OFS, 0);
    apb(1, `SAS_MODE_OFS, 32'hFF); apb(0, `SAS_MODE_OFS, 0); chk(rdata, {24'h0, `SAS_MODE_WMASK});
    apb(1, `SAS_MODE_OFS, 32'h01);
    repeat (12) @(posedge pclk);
    chk(comparator_on, 1);
    apb(1, `SAS_MASK_OFS, 0);
    $display("test registers done");
    // start, then a channel write restarts and fixes the latency
    for (i = 0; i < 4; i = i + 1) begin
      vin_bus[i*8 +: 8] = vtab[i];
      apb(1, `SAS_MODE_OFS, {24'h0, 2'h2, ttab[i], 1'h1});
      apb(1, `SAS_CHAN_OFS, i);
      wait_irq;
      chk(n >= 24 * (ttab[i] + 1) && n <= 24 * (ttab[i] + 1) + 6, 1);
      apb(0, `SAS_RESULT_OFS, 0); chk(rdata, vtab[i]);
      apb(1, `SAS_MODE_OFS, 32'h01);
      apb(1, `SAS_FLAG_OFS, 0);
      // a stopped converter stays quiet for a while before the next start
      repeat (8) @(posedge pclk);
    end
    $display("test conversions done");
    vin_bus[7:0] = 8'h3C;
    apb(1, `SAS_CHAN_OFS, 0);
    apb(1, `SAS_MODE_OFS, 32'h81);
    wait_irq;
    vin_bus[7:0] = 8'hC3;
    apb(0, `SAS_RESULT_OFS, 0); chk(rdata, 32'h3C);
    apb(1, `SAS_FLAG_OFS, 0);
    // the request output lags the flag clear by a cycle
    repeat (2) @(posedge pclk);
    wait_irq;
    apb(0, `SAS_RESULT_OFS, 0); chk(rdata, 32'hC3);
    apb(1, `SAS_MASK_OFS, 1);
    apb(1, `SAS_CHAN_OFS, 0);
    apb(0, `SAS_FLAG_OFS, 0); chk(rdata, 32'h1);
    chk(conversion_end_irq, 0);
    apb(1, `SAS_FLAG_OFS, 0);
    apb(1, `SAS_MASK_OFS, 0);
    repeat (5) @(posedge pclk);
    apb(1, `SAS_MODE_OFS, 32'h01);
    repeat (100) @(posedge pclk);
    chk(conversion_end_irq, 0);
    vin_bus[7:0] = 8'h11;
    apb(0, `SAS_RESULT_OFS, 0); chk(rdata, 32'hC3);
    apb(1, `SAS_MODE_OFS, 0);
    repeat (2) @(posedge pclk);
    chk(comparator_on, 0);
    $display("test repeat and stop done");
    results;
  end
endmodule

// >>> sas_step_timer.v
// Purpose: step pacing counter for the converter sequencer
// Assumes: pclk runs free; clear restarts the count
// Notes:   step length grows with the time-select field
`timescale 1ns/1ps

module sas_step_timer #(
  parameter SEL_W = 5
) (
  input  wire             pclk,     // peripheral clock
  input  wire             presetn,  // async reset, active low
  input  wire             clr,      // restart count
  input  wire [SEL_W-1:0] time_sel, // time-select field
  output reg              tick      // one-cycle step pulse
);

  reg  [SEL_W+1:0] cnt_q;
  wire [SEL_W+1:0] limit;

  // step length is (field + 1) * 2 cycles, never below two cycles
  assign limit = {1'b0, time_sel, 1'b1};

  // ----------------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= {(SEL_W+2){1'b0}};
      tick  <= 1'b0;
    end else if (clr) begin
      cnt_q <= {(SEL_W+2){1'b0}};
      tick  <= 1'b0;
    end else if (cnt_q == limit) begin
      cnt_q <= {(SEL_W+2){1'b0}};
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + {{(SEL_W+1){1'b0}}, 1'b1};
      tick  <= 1'b0;
    end
  end

endmodule
